// ==== verilog/lane_pkg.sv ====
`default_nettype none
package lane_pkg;
  // Bus personalities selected by the host
  typedef enum logic [1:0] {
    MODE_MEM,
    MODE_IO,
    MODE_IDE
  } mode_e;
  // Request kinds on the user port
  localparam logic [1:0] KIND_BYTE = 2'h0;
  localparam logic [1:0] KIND_WORD = 2'h1;
  localparam logic [1:0] KIND_CTRL = 2'h2;
  // Address widths
  localparam int ADDR_W = 11;
  localparam int IDE_ADDR_W = 3;
  // Reset levels of the pin drivers
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [10:0] ADDR_RST = 11'h000;
endpackage
`default_nettype wire

// ==== verilog/card_lane_host.sv ====
`default_nettype none
module card_lane_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire lane_pkg::mode_e mode,
  input wire logic ide_slave,
  input wire logic eight_bit_host,
  // Request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_kind,
  input wire logic req_odd,
  input wire logic [10:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_dma,
  // Answer port
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // Card pins
  output logic ce1_n,
  output logic ce2_n,
  output logic csel_n_o,
  output logic csel_n_oe,
  output logic dmack_n,
  output logic [10:0] addr,
  output logic [15:0] data_o,
  output logic [15:0] data_oe,
  input wire logic [15:0] data_i
);
  // Derived selection of the access
  wire is_ide = (mode == lane_pkg::MODE_IDE);
  wire is_byte = (req_kind == lane_pkg::KIND_BYTE) || eight_bit_host;
  wire is_ctrl = (req_kind == lane_pkg::KIND_CTRL);
  wire is_dma = req_dma && is_ide && !is_byte && !is_ctrl;
  // odd byte lane
  // Odd lane enable only on a 16-bit host, for word or control access or an odd byte
  wire odd_lane = !is_byte || (req_odd && !eight_bit_host);
  wire even_lane = !odd_lane || !is_byte;
  wire sel0 = is_ide && !is_dma && !is_ctrl;
  wire sel1 = is_ide && !is_dma && is_ctrl;
  wire ce1_nxt = is_ide ? !sel0 : !even_lane;
  wire ce2_nxt = is_ide ? !sel1 : !odd_lane;
  wire [10:0] addr_nxt = is_ide ?
    {{(11 - lane_pkg::IDE_ADDR_W){1'b0}}, req_addr[2:0]} :
    {req_addr[10:1], req_addr[0] | (req_odd & eight_bit_host)};
  // task file bytes on D7:D0 only
  wire [15:0] oe_nxt = !req_write ? 16'h0000 :
    (is_ide && !is_dma) ? 16'h00FF :
    (is_byte && !odd_lane) ? 16'h00FF :
    (is_byte && !even_lane) ? 16'hFF00 : 16'hFFFF;
  // odd byte sits on D15:D8 for odd-lane byte writes
  wire [15:0] wdata_nxt = (is_byte && !even_lane) ?
    {req_wdata[7:0], 8'h00} : req_wdata;

  logic [1:0] phase_r;
  logic lane_odd_r;
  logic narrow_r;
  logic [15:0] din_r1;
  logic [15:0] din_r2;

  // Pins held three cycles per access so the card sees stable selects
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_r <= 2'h0;
      ce1_n <= 1'b1;
      ce2_n <= 1'b1;
      dmack_n <= 1'b1;
      addr <= lane_pkg::ADDR_RST;
      data_o <= lane_pkg::DATA_RST;
      data_oe <= 16'h0000;
      lane_odd_r <= 1'b0;
      narrow_r <= 1'b0;
    end
    else if (phase_r == 2'h0)
    begin
      if (req_valid)
      begin
        phase_r <= 2'h1;
        ce1_n <= ce1_nxt;
        ce2_n <= ce2_nxt;
        dmack_n <= !is_dma;
        addr <= addr_nxt;
        data_o <= wdata_nxt;
        data_oe <= oe_nxt;
        lane_odd_r <= is_byte && !even_lane;
        narrow_r <= is_byte || (is_ide && !is_dma);
      end
    end
    else if (phase_r == 2'h3)
    begin
      phase_r <= 2'h0;
      ce1_n <= 1'b1;
      ce2_n <= 1'b1;
      dmack_n <= 1'b1;
      data_oe <= 16'h0000;
    end
    else
      phase_r <= phase_r + 2'h1;
  end

  // Read data crosses from the pins through two stages
  always_ff @(posedge sys_clk)
  begin
    din_r1 <= data_i;
    din_r2 <= din_r1;
  end

  // odd byte returned in the low byte
  wire [15:0] rdata_nxt = lane_odd_r ? {8'h00, din_r2[15:8]} :
    narrow_r ? {8'h00, din_r2[7:0]} : din_r2;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= lane_pkg::DATA_RST;
    end
    else
    begin
      rsp_valid <= (phase_r == 2'h3);
      rsp_rdata <= (phase_r == 2'h3) ? rdata_nxt : rsp_rdata;
    end
  end

  // strap driven low in card modes; released for IDE slave
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      csel_n_o <= 1'b0;
      csel_n_oe <= 1'b1;
    end
    else
    begin
      csel_n_o <= 1'b0;
      // master when grounded, slave when open
      csel_n_oe <= !(is_ide && ide_slave);
    end
  end

  // chip selects negated under DMA acknowledge
  property p_dma_cs;
    @(posedge sys_clk) disable iff (rst)
      !dmack_n |-> (ce1_n && ce2_n && data_oe != 16'h00FF);
  endproperty
  a_dma_cs: assert property (p_dma_cs)
    else $error("chip select active during dma acknowledge");
  property p_idle;
    @(posedge sys_clk) disable iff (rst)
      (phase_r == 2'h0) |-> (ce1_n && ce2_n && data_oe == 16'h0000);
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus driven while idle");
  property p_ide_sel;
    @(posedge sys_clk) disable iff (rst)
      (mode == lane_pkg::MODE_IDE && phase_r != 2'h0) |-> (ce1_n || ce2_n);
  endproperty
  a_ide_sel: assert property (p_ide_sel)
    else $error("both ide selects asserted");
  property p_ide_addr;
    @(posedge sys_clk) disable iff (rst)
      (mode == lane_pkg::MODE_IDE && phase_r != 2'h0) |-> addr[10:3] == 8'h00;
  endproperty
  a_ide_addr: assert property (p_ide_addr)
    else $error("ide upper address not grounded");
  // eight-bit host never uses odd lane
  property p_narrow;
    @(posedge sys_clk) disable iff (rst)
      (eight_bit_host && mode != lane_pkg::MODE_IDE && phase_r != 2'h0)
        |-> (ce2_n && !ce1_n);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("eight bit host used odd lane");
  // access lasts four cycles then answers
  property p_answer;
    @(posedge sys_clk) disable iff (rst)
      (phase_r == 2'h0 && req_valid) |-> ##3 (phase_r == 2'h3) ##1 rsp_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer not at fourth cycle");
  property p_strap;
    @(posedge sys_clk) disable iff (rst)
      $past(mode != lane_pkg::MODE_IDE) |-> (csel_n_oe && !csel_n_o);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap floating in card mode");
  // task file write on low lanes
  property p_tf;
    @(posedge sys_clk) disable iff (rst)
      (!ce1_n && ce2_n && mode == lane_pkg::MODE_IDE && data_oe != 16'h0000)
        |-> data_oe == 16'h00FF;
  endproperty
  a_tf: assert property (p_tf)
    else $error("task file write not on low lanes");
  c_word: cover property (@(posedge sys_clk) !ce1_n && !ce2_n);
  c_odd: cover property (@(posedge sys_clk) ce1_n && !ce2_n);
  c_dma: cover property (@(posedge sys_clk) !dmack_n);
  c_rsp: cover property (@(posedge sys_clk) rsp_valid);
endmodule // card_lane_host
`default_nettype wire

// ==== tb/card_model.sv ====
`default_nettype none
module card_model (
  // Host side pins
  input wire logic sys_clk,
  input wire lane_pkg::mode_e mode,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic dmack_n,
  input wire logic csel_n_o,
  input wire logic csel_n_oe,
  input wire logic [10:0] addr,
  input wire logic [15:0] data_o,
  input wire logic [15:0] data_oe,
  // Card answers
  output logic [15:0] data_i,
  output logic is_slave
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:7];
  logic [15:0] last_r = 16'h0000;
  logic [15:0] rd;
  wire ide = mode == lane_pkg::MODE_IDE;
  wire [2:0] ix = ide ? addr[2:0] : addr[3:1];
  wire [15:0] w = mem[ix];
  assign is_slave = csel_n_oe ? csel_n_o : 1'b1;
  always_comb
    if (!ide && !ce1_n && !ce2_n)
      rd = w;
    else if (!ide && !ce2_n)
      rd = {w[15:8], ~last_r[7:0]};
    else if (!ide && !ce1_n)
      rd = {~last_r[15:8], addr[0] ? w[15:8] : w[7:0]};
    else if (ide && !dmack_n)
      rd = w;
    else if (ide && !ce1_n)
      rd = {~last_r[15:8], w[7:0]};
    else if (ide && !ce2_n)
      rd = {~last_r[15:8], ~w[7:0]};
    else
      rd = ~last_r;
  // Host enables win; idle lanes toggle so stale data never passes
  assign data_i = (data_oe & data_o) | (~data_oe & rd);
  initial
    for (int i = 0; i < 8; i++)
      mem[i] = 16'(16'h3C00 + 16'h0101 * i);
  // Only word writes are modelled
  always @(posedge sys_clk)
  begin
    last_r <= data_i;
    if (&data_oe && ((!ide && !ce1_n && !ce2_n) || (ide && !dmack_n)))
      mem[ix] <= data_o;
  end
endmodule // card_model
`default_nettype wire

// ==== tb/card_select_data_lane_steering_tb.sv ====
`default_nettype none
module card_select_data_lane_steering_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst = 1'b1, ide_slave = 1'b0, eight_bit_host = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_odd = 1'b0, req_dma = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [10:0] req_addr = 11'h000;
  logic [15:0] req_wdata = 16'h0000, got, rsp_rdata, data_o, data_oe, data_i;
  lane_pkg::mode_e mode = lane_pkg::MODE_MEM;
  logic rsp_valid, ce1_n, ce2_n, csel_n_o, csel_n_oe, dmack_n, is_slave;
  logic [10:0] addr;
  logic [2:0] snap;
  int n_fail = 0, n_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  card_lane_host dut (.sys_clk, .rst, .mode, .ide_slave, .eight_bit_host,
    .req_valid, .req_write, .req_kind, .req_odd, .req_addr, .req_wdata,
    .req_dma, .rsp_valid, .rsp_rdata, .ce1_n, .ce2_n, .csel_n_o,
    .csel_n_oe, .dmack_n, .addr, .data_o, .data_oe, .data_i);
  card_model card (.sys_clk, .mode, .ce1_n, .ce2_n, .dmack_n, .csel_n_o,
    .csel_n_oe, .addr, .data_o, .data_oe, .data_i, .is_slave);
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One access; pins sampled mid-access, answer waited for with a bound
  task acc(input logic wr, input logic [1:0] k, input logic od,
    input logic [10:0] a, input logic [15:0] wd, input logic dm);
    int n;
    @(posedge sys_clk);
    {req_valid, req_write, req_kind, req_odd} <= {1'b1, wr, k, od};
    {req_addr, req_wdata, req_dma} <= {a, wd, dm};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 snap = {ce1_n, ce2_n, dmack_n};
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 8)
    begin
      n_fail++;
      wrap_up;
    end
    got = rsp_rdata;
  endtask
  task t_word;
    chk("strap", 16'h0002, {14'h0, csel_n_oe, csel_n_o});
    acc(1'b1, lane_pkg::KIND_WORD, 1'b0, 11'h002, 16'hBEEF, 1'b0);
    acc(1'b0, lane_pkg::KIND_WORD, 1'b0, 11'h002, 16'h0000, 1'b0);
    chk("word data", 16'hBEEF, got);
    chk("word sel", 16'h0001, {13'h0, snap});
    acc(1'b0, lane_pkg::KIND_WORD, 1'b0, 11'h004, 16'h0000, 1'b0);
    chk("word data", 16'h3E02, got);
  endtask
  task t_byte;
    acc(1'b0, lane_pkg::KIND_BYTE, 1'b1, 11'h004, 16'h0000, 1'b0);
    chk("odd byte", 16'h003E, {8'h00, got[7:0]});
    chk("odd sel", 16'h0005, {13'h0, snap});
    acc(1'b0, lane_pkg::KIND_BYTE, 1'b0, 11'h004, 16'h0000, 1'b0);
    chk("even byte", 16'h0002, {8'h00, got[7:0]});
    chk("even sel", 16'h0003, {13'h0, snap});
    @(posedge sys_clk);
    eight_bit_host <= 1'b1;
    acc(1'b0, lane_pkg::KIND_BYTE, 1'b1, 11'h004, 16'h0000, 1'b0);
    chk("narrow odd", 16'h003E, {8'h00, got[7:0]});
    chk("narrow sel", 16'h0003, {13'h0, snap});
  endtask
  task t_ide;
    @(posedge sys_clk);
    {mode, eight_bit_host} <= {lane_pkg::MODE_IDE, 1'b0};
    acc(1'b0, lane_pkg::KIND_BYTE, 1'b0, 11'h003, 16'h0000, 1'b0);
    chk("task file", 16'h0003, {8'h00, got[7:0]});
    chk("task sel", 16'h0003, {13'h0, snap});
    chk("master", 16'h0000, {15'h0, is_slave});
    acc(1'b0, lane_pkg::KIND_CTRL, 1'b0, 11'h006, 16'h0000, 1'b0);
    chk("control", 16'h00F9, {8'h00, got[7:0]});
    chk("ctrl sel", 16'h0005, {13'h0, snap});
    acc(1'b0, lane_pkg::KIND_WORD, 1'b0, 11'h005, 16'h0000, 1'b1);
    chk("dma data", 16'h4105, got);
    chk("dma sel", 16'h0006, {13'h0, snap});
    @(posedge sys_clk);
    ide_slave <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("slave", 16'h0001, {15'h0, is_slave});
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_word;
    t_byte;
    t_ide;
    wrap_up;
  end
endmodule // card_select_data_lane_steering_tb
`default_nettype wire
